// ---- design/lhp_pkg.sv ----
// Functional notes
// - Command/data select low means command index, high means pixel data.
// - Pixel bus width is 8, 9, 16 or 18 bits by configuration.
// - Both i80 strobes and M68 enable plus direction are accepted.
// - 16-bit byte order 00, 01, 1x packs colour words differently.
// - Reads return the latch from the previous read; first read is dummy.
// - Address counter advances after every pixel read and every pixel write the FIFO accepts, by scan setting.
// - 128-line layout: line in upper byte, column lower, 0000 to 7F7F.
// - 96-line layout uses the same split, limited to 5F5F.
// - Three scan bits pick eight orders; RGB interface forces 000.
// - 8-colour and dithering modes slow refresh from 60Hz to 40Hz.
// - Partial mode drives only rows inside the configured window.
// - Sleep still accepts writes and keeps memory contents.
// - Oscillator stops during sleep and restarts when sleep ends.
package lhp_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int RATE_NORMAL_HZ = 60;
  localparam int RATE_LOW_HZ = 40;
  localparam int LINES_PER_FRAME = 128;
  localparam int LINE_CYC_NORMAL = CLK_HZ / (RATE_NORMAL_HZ * LINES_PER_FRAME);
  localparam int LINE_CYC_LOW = CLK_HZ / (RATE_LOW_HZ * LINES_PER_FRAME);
  localparam logic [6:0] LAST_128 = 7'h7F;
  localparam logic [6:0] LAST_96 = 7'h5F;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 32;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PART = 4'h4;
  localparam logic [3:0] OFS_ADDR = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  localparam int CB_WIDTH = 0;
  localparam int CB_M68 = 2;
  localparam int CB_ORDER = 3;
  localparam int CB_SCAN = 5;
  localparam int CB_SMALL = 8;
  localparam int CB_COLOR8 = 9;
  localparam int CB_DITHER = 10;
  localparam int CB_PARTIAL = 11;
  localparam int CB_SLEEP = 12;
  localparam int CB_RGBIF = 13;
  localparam logic [13:0] CTRL_RESET = 14'h0003;
  localparam logic [15:0] PART_RESET = 16'h7F00;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_9 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_18 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/lhp_host_port.sv ----
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module lhp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_reg != rd_reg;
  assign out_data_out = mem_reg[rd_reg[AW-1:0]];
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem_reg[wr_reg[AW-1:0]] <= in_data_in;
    if (reset_in)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_reg + (AW+1)'(push);
      rd_reg <= rd_reg + (AW+1)'(pop);
    end
  end
endmodule

module lhp_host_port #(
  parameter int LINE_CYC_NORMAL = lhp_pkg::LINE_CYC_NORMAL,
  parameter int LINE_CYC_LOW = lhp_pkg::LINE_CYC_LOW
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_sel_n_in,
  input wire logic cmd_data_select_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  input wire logic [17:0] bus_data_in,
  output logic [17:0] bus_data_out,
  output logic bus_data_oe_out,
  output logic host_busy_out,
  input wire logic id_strap_in,
  output logic pix_valid_out,
  input wire logic pix_ready_in,
  output logic [31:0] pix_data_out,
  output logic [13:0] mem_rd_addr_out,
  input wire logic [17:0] mem_rd_data_in,
  output logic internal_oscillator_run_out,
  output logic line_start_out,
  output logic [6:0] line_index_out,
  output logic row_drive_out,
  output logic color8_out
);
  // Pin synchronisers: the first stage feeds only the second
  logic [22:0] pin_s1_reg;
  logic [22:0] pin_s2_reg;
  logic strobe_q_reg;
  logic was_read_reg;
  logic was_data_reg;
  logic [17:0] word_reg;
  always_ff @(posedge clk_sys_in)
  begin
    pin_s1_reg <= {chip_sel_n_in, cmd_data_select_in, wr_n_in, rd_n_in,
                   id_strap_in, bus_data_in};
    pin_s2_reg <= pin_s1_reg;
  end
  wire cs_n_s = pin_s2_reg[22];
  wire rs_s = pin_s2_reg[21];
  wire wr_n_s = pin_s2_reg[20];
  wire rd_n_s = pin_s2_reg[19];
  wire [17:0] dat_s = pin_s2_reg[17:0];

  logic [13:0] ctrl_reg;
  logic [15:0] part_reg;
  logic [7:0] cmd_index_reg;
  logic [6:0] row_reg;
  logic [6:0] col_reg;
  wire [1:0] bus_width = ctrl_reg[lhp_pkg::CB_WIDTH +: 2];
  wire m68 = ctrl_reg[lhp_pkg::CB_M68];
  wire [1:0] byte_order = ctrl_reg[lhp_pkg::CB_ORDER +: 2];
  wire sleep = ctrl_reg[lhp_pkg::CB_SLEEP];
  wire low_rate = ctrl_reg[lhp_pkg::CB_COLOR8] | ctrl_reg[lhp_pkg::CB_DITHER];
  // Parallel RGB path can only follow the plain raster order
  wire [2:0] scan = ctrl_reg[lhp_pkg::CB_RGBIF] ? 3'h0 :
                    ctrl_reg[lhp_pkg::CB_SCAN +: 3];
  wire [6:0] last = ctrl_reg[lhp_pkg::CB_SMALL] ? lhp_pkg::LAST_96 :
                    lhp_pkg::LAST_128;

  // i80 uses separate strobes; M68 uses rd_n pin as enable, wr_n as R/W
  wire strobe = !cs_n_s && (m68 ? rd_n_s : (!wr_n_s || !rd_n_s));
  wire is_read = m68 ? wr_n_s : !rd_n_s;
  wire done = strobe_q_reg && !strobe;
  wire wr_done = done && !was_read_reg;
  wire rd_done = done && was_read_reg;
  always_ff @(posedge clk_sys_in)
  begin
    strobe_q_reg <= reset_in ? 1'b0 : strobe;
    if (strobe)
    begin
      was_read_reg <= is_read;
      was_data_reg <= rs_s;
      word_reg <= dat_s;
    end
  end

  // Pixel assembly per bus width and byte order
  logic [1:0] phase_reg;
  logic [17:0] acc_reg;
  wire [1:0] words_needed = (bus_width == lhp_pkg::WIDTH_18) ? 2'd1 :
    (bus_width == lhp_pkg::WIDTH_8) ? 2'd3 :
    (bus_width == lhp_pkg::WIDTH_16 && byte_order == 2'h0) ? 2'd1 :
    2'd2;
  wire last_word = (phase_reg + 2'd1) == words_needed;
  logic [17:0] merged;
  always_comb
  begin
    merged = acc_reg;
    case (bus_width)
      lhp_pkg::WIDTH_8:
        case (phase_reg)
          2'd0: merged[17:12] = word_reg[7:2];
          2'd1: merged[11:6] = word_reg[7:2];
          default: merged[5:0] = word_reg[7:2];
        endcase
      lhp_pkg::WIDTH_9:
        if (phase_reg == 2'd0)
          merged[17:9] = word_reg[8:0];
        else
          merged[8:0] = word_reg[8:0];
      lhp_pkg::WIDTH_16:
        if (byte_order == 2'h0)
          merged = {word_reg[15:11], word_reg[15], word_reg[10:5],
                    word_reg[4:0], word_reg[4]};
        else if (byte_order == 2'h1)
          if (phase_reg == 2'd0)
            merged[17:6] = word_reg[11:0];
          else
            merged[5:0] = word_reg[5:0];
        else if (phase_reg == 2'd0)
          merged[17:2] = word_reg[15:0];
        else
          merged[1:0] = word_reg[1:0];
      default: merged = word_reg;
    endcase
  end
  wire pix_done = wr_done && was_data_reg && last_word;
  wire fifo_ready;
  // Sleep does not block pixel writes; memory is never cleared
  wire fifo_push = pix_done && fifo_ready;
  wire advance = fifo_push || (rd_done && was_data_reg);

  // Next address: X mirrors columns, Y mirrors rows, XY swaps axes
  function automatic logic [6:0] step(input logic [6:0] v,
                                      input logic down,
                                      input logic [6:0] lim);
    if (down)
      step = (v == 7'h00) ? lim : v - 7'h01;
    else
      step = (v == lim) ? 7'h00 : v + 7'h01;
  endfunction
  wire col_wrap = scan[1] ? (col_reg == 7'h00) : (col_reg == last);
  wire row_wrap = scan[0] ? (row_reg == 7'h00) : (row_reg == last);
  wire [6:0] col_next = (!scan[2] || row_wrap) ?
                        step(col_reg, scan[1], last) : col_reg;
  wire [6:0] row_next = (scan[2] || col_wrap) ?
                        step(row_reg, scan[0], last) : row_reg;

  // AXI4-Lite slave; a low ready means its word is held until the write
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  wire aw_held = !s_axi_awready;
  wire w_held = !s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = do_write && awaddr_reg == lhp_pkg::OFS_CTRL;
  wire wr_part = do_write && awaddr_reg == lhp_pkg::OFS_PART;
  wire wr_addr = do_write && awaddr_reg == lhp_pkg::OFS_ADDR;
  wire wr_hit = wr_ctrl || wr_part || wr_addr;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  logic [31:0] rd_mux;
  always_comb
  begin
    case (s_axi_araddr)
      lhp_pkg::OFS_CTRL: rd_mux = {18'h0, ctrl_reg};
      lhp_pkg::OFS_PART: rd_mux = {16'h0, part_reg};
      lhp_pkg::OFS_ADDR: rd_mux = {17'h0, row_reg, 1'b0, col_reg};
      lhp_pkg::OFS_STAT: rd_mux = {9'h0, line_index_out, 5'h0, low_rate,
                                   internal_oscillator_run_out,
                                   pin_s2_reg[18], cmd_index_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_hit = s_axi_araddr == lhp_pkg::OFS_CTRL ||
    s_axi_araddr == lhp_pkg::OFS_PART ||
    s_axi_araddr == lhp_pkg::OFS_ADDR || s_axi_araddr == lhp_pkg::OFS_STAT;
  always_ff @(posedge clk_sys_in)
  begin
    if (s_axi_awvalid && s_axi_awready)
      awaddr_reg <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    if (rd_take)
    begin
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? lhp_pkg::RESP_OKAY : lhp_pkg::RESP_SLVERR;
    end
    if (do_write)
      s_axi_bresp <= wr_hit ? lhp_pkg::RESP_OKAY : lhp_pkg::RESP_SLVERR;
    if (reset_in)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_bresp <= lhp_pkg::RESP_OKAY;
      s_axi_rresp <= lhp_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready <= do_write || (s_axi_awready && !s_axi_awvalid);
      s_axi_wready <= do_write || (s_axi_wready && !s_axi_wvalid);
      s_axi_arready <= !rd_take && !(s_axi_rvalid && !s_axi_rready);
      s_axi_bvalid <= do_write | (s_axi_bvalid & !s_axi_bready);
      s_axi_rvalid <= rd_take | (s_axi_rvalid & !s_axi_rready);
    end
  end

  // Control state; a register write to ADDR wins over auto-advance
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ctrl_reg <= lhp_pkg::CTRL_RESET;
      part_reg <= lhp_pkg::PART_RESET;
      cmd_index_reg <= 8'h00;
      row_reg <= 7'h00;
      col_reg <= 7'h00;
      phase_reg <= 2'd0;
      acc_reg <= 18'h0_0000;
    end
    else
    begin
      if (wr_ctrl && wstrb_reg[0])
        ctrl_reg[7:0] <= wdata_reg[7:0];
      if (wr_ctrl && wstrb_reg[1])
        ctrl_reg[13:8] <= wdata_reg[13:8];
      if (wr_part && wstrb_reg[0])
        part_reg[7:0] <= wdata_reg[7:0];
      if (wr_part && wstrb_reg[1])
        part_reg[15:8] <= wdata_reg[15:8];
      if (wr_addr)
      begin
        row_reg <= wdata_reg[14:8];
        col_reg <= wdata_reg[6:0];
      end
      else if (advance)
      begin
        row_reg <= row_next;
        col_reg <= col_next;
      end
      if (wr_done && !was_data_reg)
      begin
        cmd_index_reg <= word_reg[7:0];
        phase_reg <= 2'd0;
      end
      else if (wr_done && (!last_word || fifo_ready))
      begin
        acc_reg <= merged;
        phase_reg <= last_word ? 2'd0 : phase_reg + 2'd1;
      end
    end
  end

  // Read latch lags one access, so the first read after writes is dummy
  logic [17:0] latch_reg;
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      latch_reg <= 18'h0_0000;
      bus_data_out <= 18'h0_0000;
      bus_data_oe_out <= 1'b0;
      host_busy_out <= 1'b0;
      mem_rd_addr_out <= 14'h0000;
    end
    else
    begin
      if (rd_done)
        latch_reg <= was_data_reg ? mem_rd_data_in :
                     {10'h000, cmd_index_reg};
      bus_data_oe_out <= strobe && is_read;
      bus_data_out <= latch_reg;
      host_busy_out <= !fifo_ready;
      mem_rd_addr_out <= {row_reg, col_reg};
    end
  end

  lhp_fifo #(
    .WIDTH(lhp_pkg::FIFO_WIDTH),
    .DEPTH(lhp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_ready),
    .in_data_in({row_reg, col_reg, merged}),
    .out_valid_out(pix_valid_out),
    .out_ready_in(pix_ready_in),
    .out_data_out(pix_data_out)
  );

  // Line timing; the counter stands still while asleep
  logic [22:0] line_cnt_reg;
  wire [22:0] line_len = low_rate ? 23'(LINE_CYC_LOW) :
                         23'(LINE_CYC_NORMAL);
  wire line_end = line_cnt_reg >= line_len - 23'd1;
  wire [6:0] line_nxt = line_index_out + 7'h01;
  wire in_window = line_nxt >= part_reg[6:0] && line_nxt <= part_reg[14:8];
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      line_cnt_reg <= 23'd0;
      line_index_out <= 7'h00;
      line_start_out <= 1'b0;
      row_drive_out <= 1'b0;
      internal_oscillator_run_out <= 1'b0;
      color8_out <= 1'b0;
    end
    else
    begin
      internal_oscillator_run_out <= !sleep;
      color8_out <= low_rate;
      line_start_out <= !sleep && line_end;
      if (!sleep)
      begin
        line_cnt_reg <= line_end ? 23'd0 : line_cnt_reg + 23'd1;
        if (line_end)
        begin
          line_index_out <= line_nxt;
          row_drive_out <= !ctrl_reg[lhp_pkg::CB_PARTIAL] || in_window;
        end
      end
      else
        row_drive_out <= 1'b0;
    end
  end

  sequence s_read_end;
    $fell(strobe_q_reg) && was_read_reg;
  endsequence
  a_read_lags_latch: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) s_read_end |=> bus_data_out == $past(latch_reg))
    else $error("read data not from previous latch");
  a_osc_sleep_stop: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) sleep |=> !internal_oscillator_run_out)
    else $error("oscillator runs in sleep");
  a_sleep_line_hold: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) sleep && $past(sleep) |-> $stable(line_index_out))
    else $error("line counter moves in sleep");
  a_addr_in_range: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) advance && row_reg <= last && col_reg <= last
    |=> row_reg <= $past(last) && col_reg <= $past(last))
    else $error("address beyond last line or column");
  a_raster_step: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) advance && !wr_addr && scan == 3'h0 && col_reg != last
    |=> col_reg == $past(col_reg) + 7'h01 && $stable(row_reg))
    else $error("raster order did not step column");
  a_rgb_scan_zero: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) ctrl_reg[lhp_pkg::CB_RGBIF] |-> scan == 3'h0)
    else $error("scan order not 000 with RGB interface");
  a_cmd_index_load: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) wr_done && !was_data_reg
    |=> cmd_index_reg == $past(word_reg[7:0]) && !$past(fifo_push))
    else $error("command write mishandled");
  a_low_rate_len: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) low_rate && line_cnt_reg < 23'(LINE_CYC_NORMAL) |-> !line_end)
    else $error("low rate line ended at normal length");
  a_partial_blank: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) !sleep && line_end && ctrl_reg[lhp_pkg::CB_PARTIAL]
    && !in_window |=> !row_drive_out)
    else $error("row outside window driven");
  a_sleep_write_ok: assert property (@(posedge clk_sys_in) disable iff
    (reset_in) sleep && pix_done && fifo_ready |=> pix_valid_out)
    else $error("pixel write lost in sleep");
endmodule

// ---- tb/lhp_host_model.sv ----
`timescale 1ns/1ps
module lhp_host_model (
  input wire logic clk_in,
  input wire logic [17:0] rd_data_in,
  output logic cs_n_out,
  output logic rs_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic [17:0] data_out
);
  logic m68;
  initial
  begin
    m68 = 1'b0;
    cs_n_out = 1'b1;
    rs_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    data_out = 18'h00000;
  end
  // Only switched while deselected, so no stray strobe is seen
  task automatic set_mode(input logic m);
    @(posedge clk_in);
    m68 <= m;
    rd_n_out <= ~m;
    wr_n_out <= 1'b1;
  endtask
  // Strobe and hold phases last 6 clocks each, three times what the two-stage pin synchroniser needs
  task automatic xfer(input logic rd, input logic rs, input logic [17:0] d,
    output logic [17:0] q);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    rs_out <= rs;
    data_out <= rd ? ~d : d;
    wr_n_out <= m68 ? rd : 1'b1;
    repeat (2) @(posedge clk_in);
    if (m68)
      rd_n_out <= 1'b1;
    else if (rd)
      rd_n_out <= 1'b0;
    else
      wr_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    q = rd_data_in;
    rd_n_out <= ~m68;
    if (!m68)
      wr_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    cs_n_out <= 1'b1;
    data_out <= ~d;
    wr_n_out <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask
endmodule

// ---- tb/test_lcd_parallel_host_port.sv ----
`timescale 1ns/1ps
module test_lcd_parallel_host_port;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, pdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic cs_n, rs, wr_n, rd_n, oe, busy, pvalid, osc, lstart, rowd, c8;
  logic pready = 1'b1;
  logic [17:0] hdata, qdata, mdata, q;
  logic [13:0] maddr;
  logic [6:0] lidx;
  int fail_count = 0, checks = 0, n;
  logic [31:0] pix_q[$];
  // Memory stand-in returns its own address, line in the upper byte
  assign mdata = {3'h0, maddr[13:7], 1'b0, maddr[6:0]};
  always #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
    if (pvalid === 1'b1 && pready === 1'b1)
      pix_q.push_back(pdata);
  lhp_host_model host (.clk_in(clk_sys_in), .rd_data_in(qdata),
    .cs_n_out(cs_n), .rs_out(rs), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .data_out(hdata));
  lhp_host_port #(.LINE_CYC_NORMAL(20), .LINE_CYC_LOW(30)) dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chip_sel_n_in(cs_n), .cmd_data_select_in(rs), .wr_n_in(wr_n),
    .rd_n_in(rd_n), .bus_data_in(hdata), .bus_data_out(qdata),
    .bus_data_oe_out(oe), .host_busy_out(busy), .id_strap_in(1'b1),
    .pix_valid_out(pvalid), .pix_ready_in(pready), .pix_data_out(pdata),
    .mem_rd_addr_out(maddr), .mem_rd_data_in(mdata),
    .internal_oscillator_run_out(osc), .line_start_out(lstart),
    .line_index_out(lidx), .row_drive_out(rowd), .color8_out(c8));
  task automatic check(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic px(input logic rd, input logic sel, input logic [17:0] v);
    host.xfer(rd, sel, v, q);
  endtask
  task automatic wait_line();
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end while (lstart !== 1'b1);
  endtask
  task automatic t_regs();
    axr(lhp_pkg::OFS_CTRL);
    check(d, 32'h00000003, "ctrl reset");
    axr(lhp_pkg::OFS_PART);
    check(d, 32'h00007F00, "part reset");
    axr(lhp_pkg::OFS_STAT);
    check(32'(d[9:8]), 32'h3, "stat strap osc");
    axr(4'h2);
    check(32'(r), 32'(lhp_pkg::RESP_SLVERR), "unmapped read");
    check(d, 32'h0000_0000, "unmapped data");
    axw(lhp_pkg::OFS_STAT, 32'h0);
    check(32'(r), 32'(lhp_pkg::RESP_SLVERR), "stat write");
    $display("done regs");
  endtask
  task automatic t_addr(input logic [15:0] c, s, n1, n2);
    pix_q.delete();
    axw(lhp_pkg::OFS_CTRL, 32'(c));
    axw(lhp_pkg::OFS_ADDR, 32'(s));
    px(0, 0, 18'h0002C);
    px(0, 1, 18'h3F0C3);
    px(0, 1, 18'h15A5A);
    repeat (4) @(posedge clk_sys_in);
    check(32'(pix_q.size()), 32'h2, "pixel count");
    check(pix_q[0], {s[14:8], s[6:0], 18'h3F0C3}, "pixel 0");
    check(pix_q[1], {n1[14:8], n1[6:0], 18'h15A5A}, "pixel 1");
    check(32'(maddr), 32'({n2[14:8], n2[6:0]}), "counter");
    axr(lhp_pkg::OFS_STAT);
    check(32'(d[7:0]), 32'h2C, "command index");
    $display("done addr %h", s);
  endtask
  task automatic t_read();
    axw(lhp_pkg::OFS_CTRL, 32'h0003);
    axw(lhp_pkg::OFS_ADDR, 32'h0305);
    px(1, 1, 18'h00000);
    host.xfer(1, 1, 18'h00000, q);
    check(32'(q), 32'h00305, "read after dummy");
    check(32'(maddr), 32'h0187, "read advance");
    check(32'(oe), 32'h0, "bus released");
    $display("done read");
  endtask
  task automatic t_sleep();
    axw(lhp_pkg::OFS_CTRL, 32'h1003);
    repeat (4) @(posedge clk_sys_in);
    check(32'(osc), 32'h0, "osc in sleep");
    axw(lhp_pkg::OFS_PART, 32'h0503);
    axr(lhp_pkg::OFS_PART);
    check(d, 32'h0503, "write in sleep");
    pix_q.delete();
    px(0, 1, 18'h00ABC);
    check(32'(pix_q.size()), 32'h1, "pixel in sleep");
    axr(lhp_pkg::OFS_STAT);
    check(32'(d[9]), 32'h0, "stat osc");
    axw(lhp_pkg::OFS_CTRL, 32'h0003);
    repeat (4) @(posedge clk_sys_in);
    check(32'(osc), 32'h1, "osc restart");
    $display("done sleep");
  endtask
  task automatic t_rate(input logic [15:0] c, input int p);
    axw(lhp_pkg::OFS_CTRL, 32'(c));
    wait_line();
    wait_line();
    wait_line();
    check(32'(n), 32'(p), "line period");
    check(32'(c8), 32'(c[9] | c[10]), "colour8 flag");
    $display("done rate %h", c);
  endtask
  task automatic t_part();
    axw(lhp_pkg::OFS_PART, 32'h0302);
    axw(lhp_pkg::OFS_CTRL, 32'h0803);
    wait_line();
    for (int i = 0; i < 128; i++)
    begin
      wait_line();
      repeat (5) @(posedge clk_sys_in);
      check(32'(rowd), 32'(lidx >= 7'h02 && lidx <= 7'h03), "row");
    end
    $display("done partial");
  endtask
  // Host would normally poll busy; here it is the thing under test
  task automatic t_fifo();
    axw(lhp_pkg::OFS_CTRL, 32'h0003);
    axw(lhp_pkg::OFS_ADDR, 32'h0000);
    pix_q.delete();
    pready <= 1'b0;
    px(0, 0, 18'h0002C);
    for (int i = 0; i < 8; i++)
      px(0, 1, 18'(i));
    check(32'(busy), 32'h1, "busy when full");
    check(32'(pix_q.size()), 32'h0, "stalled");
    pready <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    check(32'(pix_q.size()), 32'h8, "drained");
    check(pix_q[7], 32'h001C0007, "last pixel");
    check(32'(busy), 32'h0, "busy cleared");
    $display("done fifo");
  endtask
  task automatic t_px(input logic m, input logic [15:0] c, input int k,
    input logic [17:0] w0, w1, w2, p);
    axw(lhp_pkg::OFS_CTRL, 32'(c));
    axw(lhp_pkg::OFS_ADDR, 32'h0000);
    host.set_mode(m);
    pix_q.delete();
    px(0, 0, 18'h0002C);
    px(0, 1, w0);
    if (k > 1)
      px(0, 1, w1);
    if (k > 2)
      px(0, 1, w2);
    repeat (4) @(posedge clk_sys_in);
    check(32'(pix_q.size()), 32'h1, "packed count");
    check(pix_q[0], 32'(p), "packed pixel");
    $display("done width %h", c);
  endtask
  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_sys_in);
    fail_count++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    t_regs();
    t_addr(16'h0003, 16'h017E, 16'h017F, 16'h0200);
    t_addr(16'h0103, 16'h005F, 16'h0100, 16'h0101);
    t_addr(16'h2043, 16'h0005, 16'h0006, 16'h0007);
    t_read();
    t_sleep();
    t_rate(16'h0003, 20);
    t_rate(16'h0203, 30);
    t_rate(16'h0403, 30);
    t_part();
    t_fifo();
    t_px(1, 16'h0004, 3, 18'hFC, 18'h00, 18'h54, 18'h3F015);
    t_px(0, 16'h0001, 2, 18'h157, 18'h115, 0, 18'h2AF15);
    t_px(0, 16'h0002, 1, 18'h8410, 0, 0, 18'h21821);
    t_px(0, 16'h000A, 2, 18'h0ABC, 18'h15, 0, 18'h2AF15);
    t_px(0, 16'h0012, 2, 18'hABC5, 18'h1, 0, 18'h2AF15);
    t_px(1, 16'h0007, 1, 18'h2AF15, 0, 0, 18'h2AF15);
    conclude();
  end
endmodule
